// File: common/sllc_pkg.sv
package sllc_pkg;

  // Register byte offsets
  localparam logic [11:0] SLLC_OFS_ILAS_LINK_TEST = 12'h574;  // Delay and test select
  localparam logic [11:0] SLLC_OFS_MF_PHASE       = 12'h578;  // Multiframe phase offset
  localparam logic [11:0] SLLC_OFS_LINK_STATUS    = 12'h57c;  // Block status, read only

  // Reset values
  localparam logic [7:0] SLLC_RST_ILAS_LINK_TEST = 8'h00;
  localparam logic [7:0] SLLC_RST_MF_PHASE       = 8'h00;

  // Field positions
  localparam int SLLC_DELAY_LSB = 4;  // Delay field [7:4]
  localparam int SLLC_DELAY_W   = 4;
  localparam int SLLC_TEST_LSB  = 0;  // Test field [2:0]
  localparam int SLLC_TEST_W    = 3;
  localparam int SLLC_PHASE_W   = 5;  // Phase field [4:0]

  // Default multiframe length in link-clock cycles
  localparam int SLLC_MF_CYCLES = 32;

  // Fixed code groups
  localparam logic [7:0] SLLC_D21_5   = 8'hb5;  // D21.5 data octet
  localparam logic [7:0] SLLC_K28_5   = 8'hbc;  // Comma
  localparam logic [7:0] SLLC_K28_0   = 8'h1c;  // Multiframe start
  localparam logic [7:0] SLLC_K28_3   = 8'h7c;  // Lane alignment
  localparam logic [7:0] SLLC_K28_4   = 8'h9c;  // Config marker
  localparam logic [7:0] SLLC_JSPAT_SEED = 8'h5a;  // Jitter pattern generator seed

  // Link-layer test codes
  typedef enum logic [2:0]
  {
    SLLC_TEST_NORMAL = 3'h0,
    SLLC_TEST_D215   = 3'h1,
    SLLC_TEST_RPAT   = 3'h4,
    SLLC_TEST_JSPAT  = 3'h5,
    SLLC_TEST_JTSPAT = 3'h6
  } sllc_test_e;

  // Link phases, one-hot
  typedef enum logic [3:0]
  {
    SLLC_ST_SYNC = 4'b0001,
    SLLC_ST_WAIT = 4'b0010,
    SLLC_ST_ILAS = 4'b0100,
    SLLC_ST_DATA = 4'b1000
  } sllc_state_e;

  // One octet for the encoder, with control flag
  typedef struct packed
  {
    logic       is_ctrl;
    logic [7:0] octet;
  } sllc_char_s;

endpackage

// File: core/sllc_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none

// Produces one link-layer test character per cycle for the chosen code
module sllc_pattern_gen
  import sllc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [2:0] test_sel,
  output sllc_char_s      pat_char
);

  logic [4:0] idx_reg;    // Pattern position
  logic [7:0] lfsr_reg;   // Pseudo-random source for jitter patterns
  sllc_char_s pat_next;   // Combinational character

  // Position counter and pattern source
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      idx_reg  <= 5'h00;
      lfsr_reg <= SLLC_JSPAT_SEED;
    end
    else
    begin
      idx_reg  <= idx_reg + 5'h01;
      lfsr_reg <= {lfsr_reg[6:0], lfsr_reg[7] ^ lfsr_reg[5] ^ lfsr_reg[4] ^ lfsr_reg[3]};
    end
  end

  // Character select by test code
  always_comb
  begin
    pat_next.is_ctrl = 1'b0;
    pat_next.octet   = 8'h00;
    case (test_sel)
      SLLC_TEST_D215:
        pat_next.octet = SLLC_D21_5;  // [R3]
      SLLC_TEST_RPAT:
      begin
        // Ramp octets mixed with a comma once per pass
        pat_next.is_ctrl = (idx_reg == 5'h00);  // [R4]
        pat_next.octet   = (idx_reg == 5'h00) ? SLLC_K28_5 : {3'h0, idx_reg} ^ 8'hbe;  // [R4]
      end
      SLLC_TEST_JSPAT:
        pat_next.octet = lfsr_reg;  // [R4]
      SLLC_TEST_JTSPAT:
      begin
        // Jitter pattern framed by alignment characters
        pat_next.is_ctrl = (idx_reg[3:0] == 4'h0);  // [R4]
        pat_next.octet   = (idx_reg[3:0] == 4'h0) ? SLLC_K28_3 : lfsr_reg;  // [R4]
      end
      default:
      begin
        pat_next.is_ctrl = 1'b0;  // Reserved codes send zero data
        pat_next.octet   = 8'h00;
      end
    endcase
  end

  // Registered output
  always_ff @(posedge clk)
  begin
    if (srst)
      pat_char <= '0;
    else
      pat_char <= pat_next;
  end

endmodule

`default_nettype wire

// File: core/sllc_link_ctrl.sv
// The strobed register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

// Contract
// R1: Start alignment on boundary N+1 after release
// R2: Test code zero passes normal data
// R3: Code one sends continuous D21.5
// R4: Codes four, five, six select patterns
// R5: SYSREF loads phase counter with offset
// R6: Software avoids reserved codes 2,3,7
module sllc_link_ctrl
  import sllc_pkg::*;
#(
  parameter int MF_CYCLES = SLLC_MF_CYCLES,  // Multiframe length in cycles
  parameter int ILAS_MFS  = 4                // Multiframes of alignment sequence
)
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic [11:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       sync_request_input,  // Active-low sync request pin
  input  wire logic       sysref,
  input  wire sllc_char_s user_char,
  output sllc_char_s      tx_char,
  output logic            mf_boundary,
  output logic            ilas_active
);

  // Elaboration check on parameters
  // Phase counter is five bits, alignment counter four
  if (MF_CYCLES < 2 || MF_CYCLES > 32 || ILAS_MFS < 1 || ILAS_MFS > 16)
  begin : g_bad_params
    $error("sllc_link_ctrl: unsupported parameters");
  end

  // Configuration registers
  logic [7:0]  ctl_reg;        // Delay and test select register
  logic [4:0]  phase_reg;      // Phase offset register
  // Synchronisers and counters
  logic [1:0]  sync_sy_reg;    // Pin synchroniser
  logic [1:0]  sref_sy_reg;    // Pin synchroniser
  logic        sref_d_reg;     // Previous synchronised SYSREF
  logic [4:0]  lmfc_reg;       // Multiframe phase counter
  logic [4:0]  wait_reg;       // Boundaries still to skip
  logic [3:0]  ilas_cnt_reg;   // Alignment multiframes sent
  logic [4:0]  oct_reg;        // Octet within alignment multiframe
  // Link phase and character path
  sllc_state_e st_reg;         // Link phase
  sllc_state_e st_next;
  sllc_char_s  pat_char;       // Test character
  sllc_char_s  char_next;      // Output character before register
  // Decode helpers
  logic        lmfc_wrap;      // Phase counter at last cycle
  logic        sync_req;       // Synchronised request, active high
  logic        sref_rise;      // SYSREF rising edge
  logic [3:0]  delay_fld;
  logic [2:0]  test_fld;

  // Field slices of the control register
  assign delay_fld = ctl_reg[SLLC_DELAY_LSB +: SLLC_DELAY_W];
  assign test_fld  = ctl_reg[SLLC_TEST_LSB +: SLLC_TEST_W];
  // Pin is active low; high here means hold commas
  assign sync_req  = ~sync_sy_reg[1];
  // One pulse per SYSREF rising edge, after the synchroniser
  assign sref_rise = sref_sy_reg[1] & ~sref_d_reg;
  // Last cycle of a multiframe
  assign lmfc_wrap = (lmfc_reg == 5'(MF_CYCLES - 1));

  // Pin synchronisers
  // Both pins come from outside this clock; two stages each
  // SYSREF edge detect runs on the synchronised copy
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      sync_sy_reg <= 2'h0;
      sref_sy_reg <= 2'h0;
      sref_d_reg  <= 1'b0;
    end
    else
    begin
      // Shift in the raw pin levels
      sync_sy_reg <= {sync_sy_reg[0], sync_request_input};
      sref_sy_reg <= {sref_sy_reg[0], sysref};
      sref_d_reg  <= sref_sy_reg[1];
    end
  end

  // Register writes; reserved bit 3 and [7:5] hold zero
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl_reg   <= SLLC_RST_ILAS_LINK_TEST;
      phase_reg <= SLLC_RST_MF_PHASE[4:0];
    end
    else if (reg_wr)
    begin
      // Delay and test code; unmapped writes are dropped
      // Reserved bit 3 stays zero
      if (reg_addr == SLLC_OFS_ILAS_LINK_TEST)
        ctl_reg <= {reg_wdata[7:4], 1'b0, reg_wdata[2:0]};
      // Phase offset, low five bits kept
      else if (reg_addr == SLLC_OFS_MF_PHASE)
        phase_reg <= reg_wdata[4:0];
    end
  end

  // Register reads, one cycle later; unmapped reads zero
  always_ff @(posedge clk)
  begin
    if (srst)
      reg_rdata <= 8'h00;
    else if (reg_rd)
    begin
      // Read data stand one cycle, zero otherwise
      // Status: link phase, then synced request
      case (reg_addr)
        SLLC_OFS_ILAS_LINK_TEST: reg_rdata <= ctl_reg;
        SLLC_OFS_MF_PHASE:       reg_rdata <= {3'h0, phase_reg};
        SLLC_OFS_LINK_STATUS:    reg_rdata <= {st_reg, sync_req, 3'h0};
        // Unmapped places read zero
        default:                 reg_rdata <= 8'h00;
      endcase
    end
    else
      reg_rdata <= 8'h00;
  end

  // Multiframe phase counter
  // A phase beyond the multiframe length runs past the wrap
  // point and rolls over; software keeps it in range
  always_ff @(posedge clk)
  begin
    if (srst)
      lmfc_reg <= 5'h00;
    // SYSREF reload wins over the wrap
    else if (sref_rise)
      lmfc_reg <= phase_reg;  // [R5]
    else if (lmfc_wrap)
      lmfc_reg <= 5'h00;
    else
      lmfc_reg <= lmfc_reg + 5'h01;
  end

  // Boundary pulse output
  // Marks the cycle after the last multiframe count
  always_ff @(posedge clk)
  begin
    if (srst)
      mf_boundary <= 1'b0;
    else
      mf_boundary <= lmfc_wrap;
  end

  // Link phase next state
  always_comb
  begin
    // Default holds the state
    st_next = st_reg;
    unique case (st_reg)
      // Commas until the request is released
      SLLC_ST_SYNC:
        if (!sync_req)
          st_next = SLLC_ST_WAIT;
      // Count boundaries; a new request aborts
      SLLC_ST_WAIT:
        if (sync_req)
          st_next = SLLC_ST_SYNC;
        else if (lmfc_wrap && wait_reg == 5'h00)
          st_next = SLLC_ST_ILAS;  // [R1]
      // Alignment multiframes, then data
      SLLC_ST_ILAS:
        if (sync_req)
          st_next = SLLC_ST_SYNC;
        else if (lmfc_wrap && ilas_cnt_reg == 4'(ILAS_MFS - 1))
          st_next = SLLC_ST_DATA;
      // Normal data until a new request
      SLLC_ST_DATA:
        if (sync_req)
          st_next = SLLC_ST_SYNC;
      // Illegal codes fall back to sync
      default:
        st_next = SLLC_ST_SYNC;
    endcase
  end

  // Link phase register
  // Returns to sync on reset
  always_ff @(posedge clk)
  begin
    if (srst)
      st_reg <= SLLC_ST_SYNC;
    else
      st_reg <= st_next;
  end

  // Boundary wait counter: skip N boundaries, start on the next
  // Reloaded while in sync, so a new delay takes effect
  // at the next release
  always_ff @(posedge clk)
  begin
    if (srst)
      wait_reg <= 5'h00;
    else if (st_reg == SLLC_ST_SYNC)
      wait_reg <= {1'b0, delay_fld};  // [R1]
    // Count down one per boundary while waiting
    else if (st_reg == SLLC_ST_WAIT && lmfc_wrap && wait_reg != 5'h00)
      wait_reg <= wait_reg - 5'h01;  // [R1]
  end

  // Alignment multiframe and octet counters
  // Cleared outside the alignment phase
  always_ff @(posedge clk)
  begin
    if (srst || st_reg != SLLC_ST_ILAS)
    begin
      ilas_cnt_reg <= 4'h0;
      oct_reg      <= 5'h00;
    end
    // Octet index restarts at each multiframe
    else if (lmfc_wrap)
    begin
      ilas_cnt_reg <= ilas_cnt_reg + 4'h1;
      oct_reg      <= 5'h00;
    end
    else
      oct_reg <= oct_reg + 5'h01;
  end

  // Character select
  always_comb
  begin
    // Normal data by default
    char_next = user_char;  // [R2]
    // Test codes win over every link phase
    if (test_fld != SLLC_TEST_NORMAL)
      char_next = pat_char;  // [R3] [R4]
    // Commas in sync and while waiting for the start boundary
    else if (st_reg == SLLC_ST_SYNC || st_reg == SLLC_ST_WAIT)
    begin
      char_next.is_ctrl = 1'b1;
      char_next.octet   = SLLC_K28_5;
    end
    // Start marker, config marker in the second
    // multiframe, lane marker at each end
    else if (st_reg == SLLC_ST_ILAS)
    begin
      char_next.is_ctrl = 1'b0;
      char_next.octet   = {3'h0, oct_reg};
      if (oct_reg == 5'h00)
      begin
        char_next.is_ctrl = 1'b1;
        char_next.octet   = SLLC_K28_0;
      end
      else if (oct_reg == 5'h01 && ilas_cnt_reg == 4'h1)
      begin
        char_next.is_ctrl = 1'b1;
        char_next.octet   = SLLC_K28_4;
      end
      else if (lmfc_wrap)
      begin
        char_next.is_ctrl = 1'b1;
        char_next.octet   = SLLC_K28_3;
      end
    end
  end

  // Registered link outputs
  // One cycle of latency on every link output
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      tx_char     <= '0;
      ilas_active <= 1'b0;
    end
    else
    begin
      tx_char     <= char_next;
      // Alignment flag lags the state by one cycle
      ilas_active <= (st_reg == SLLC_ST_ILAS);
    end
  end

  // Test pattern source
  // Pattern output is registered, one cycle ahead of tx_char
  sllc_pattern_gen u_pat
  (
    .clk      (clk),
    .srst     (srst),
    .test_sel (test_fld),
    .pat_char (pat_char)
  );

endmodule

`default_nettype wire

// File: testbench/sllc_link_ctrl_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the link control block
module sllc_link_ctrl_checker
  import sllc_pkg::*;
(
  input wire logic        clk,
  input wire logic        srst,
  input wire logic [11:0] reg_addr,
  input wire logic [7:0]  reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_rdata,
  input wire logic        sync_request_input,
  input wire sllc_char_s  tx_char,
  input wire logic        mf_boundary,
  input wire logic        ilas_active
);
  logic [7:0] ctl_q;  // Mirror of delay and test register
  logic [4:0] ph_q;   // Mirror of phase register
  // Track writes, reserved bit dropped
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      ctl_q <= 8'h00;
      ph_q  <= 5'h00;
    end
    else if (reg_wr && reg_addr == SLLC_OFS_ILAS_LINK_TEST)
      ctl_q <= reg_wdata & 8'hf7;
    else if (reg_wr && reg_addr == SLLC_OFS_MF_PHASE)
      ph_q <= reg_wdata[4:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  chk_ctl_read_back: assert property ($past(reg_rd && reg_addr == SLLC_OFS_ILAS_LINK_TEST)
    |-> reg_rdata == $past(ctl_q)) else $error("control readback wrong");
  chk_phase_read_back: assert property ($past(reg_rd && reg_addr == SLLC_OFS_MF_PHASE)
    |-> reg_rdata == {3'h0, $past(ph_q)}) else $error("phase readback wrong");
  chk_d215_stream: assert property ((ctl_q[2:0] == 3'h1) [*4]
    |-> tx_char == {1'b0, SLLC_D21_5}) else $error("test stream not D21.5");
  chk_ilas_on_boundary: assert property ($rose(ilas_active)
    |-> mf_boundary || $past(mf_boundary) || $past(mf_boundary, 2)) else $error("alignment off boundary");
  chk_ilas_after_release: assert property ($rose(ilas_active)
    |-> sync_request_input && $past(sync_request_input, 3)) else $error("alignment without release");
  chk_ilas_first_char: assert property ($rose(ilas_active) && ctl_q[2:0] == 3'h0
    |-> ##[0:1] tx_char == {1'b1, SLLC_K28_0}) else $error("alignment start char wrong");
endmodule
`default_nettype wire

// File: testbench/sllc_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end receiver: holds sync until commas seen and bench allows
module sllc_rx_model
  import sllc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       release_req,  // Bench permits leaving sync
  input  wire sllc_char_s rx_char,
  output logic            sync_request_input
);
  logic [2:0] comma_cnt;  // Commas in a row while in sync
  initial
  begin
    comma_cnt = 3'h0;
    sync_request_input = 1'b0;
  end
  // Count commas, release only after four
  always @(posedge clk)
  begin
    if (rx_char == {1'b1, SLLC_K28_5})
      comma_cnt <= (comma_cnt == 3'h4) ? comma_cnt : comma_cnt + 3'h1;
    else if (!sync_request_input)
      comma_cnt <= 3'h0;
    sync_request_input <= release_req && (comma_cnt == 3'h4 || sync_request_input);
  end
endmodule
`default_nettype wire

// File: testbench/tb_sllc_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Self-checking bench for the link control block
module tb_sllc_link_ctrl;
  import sllc_pkg::*;
  logic        clk, srst, reg_wr, reg_rd, sysref, rel, mfb, ilas, sync_request_input, rd_d, mk, ch;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, v;
  sllc_char_s  user_char, tx_char;
  logic [8:0]  h[3];
  logic [7:0]  exp_q[$];  // Expected read data
  logic [3:0]  dl[3] = '{4'h0, 4'h1, 4'hf};
  logic [2:0]  cd[4] = '{3'h1, 3'h4, 3'h5, 3'h6};  // reserved codes left out
  int          bad_count, comparisons, n, cnt, dd[2];

  sllc_link_ctrl #(.MF_CYCLES(8), .ILAS_MFS(4)) uut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_request_input(sync_request_input), .sysref(sysref), .user_char(user_char),
    .tx_char(tx_char), .mf_boundary(mfb), .ilas_active(ilas));
  sllc_rx_model rx (.clk(clk), .release_req(rel), .rx_char(tx_char), .sync_request_input(sync_request_input));

  // Clock, 25 ns period
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches %0d of %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Bus cycles, strobes left for the next call or idle
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1; reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_addr <= a; reg_rd <= 1'b1; reg_wr <= 1'b0; exp_q.push_back(e);
    @(posedge clk);
  endtask
  task automatic idle();
    reg_wr <= 1'b0; reg_rd <= 1'b0;
    @(posedge clk);
  endtask

  // Read data watcher, oldest note first
  always @(posedge clk)
  begin
    if (rd_d)
      check({1'b0, reg_rdata}, {1'b0, exp_q.pop_front()});
    rd_d <= reg_rd;
  end

  // Hang guard
  initial
  begin
    repeat (6000) @(posedge clk);
    bad_count++;
    $display("CHECK FAILED t=%0t watchdog", $time);
    wrap_up();
  end

  initial
  begin
    {srst, reg_wr, reg_rd, sysref, rel} = 5'b10000;
    reg_addr = 12'h000; reg_wdata = 8'h00; user_char = 9'h000;
    void'($urandom(32'h28bdeac7));
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    // Reset values, readback, unmapped place
    rd(SLLC_OFS_ILAS_LINK_TEST, SLLC_RST_ILAS_LINK_TEST);
    rd(SLLC_OFS_LINK_STATUS, 8'h18);
    rd(SLLC_OFS_MF_PHASE, SLLC_RST_MF_PHASE);
    v = 8'($urandom);
    wr(SLLC_OFS_MF_PHASE, v);
    rd(SLLC_OFS_MF_PHASE, {3'h0, v[4:0]});
    wr(12'h570, 8'hff);
    rd(12'h570, 8'h00);
    wr(SLLC_OFS_ILAS_LINK_TEST, 8'h08);
    rd(SLLC_OFS_ILAS_LINK_TEST, 8'h00);
    idle();
    $display("registers done");
    // Boundary count to alignment, then normal data
    foreach (dl[i])
    begin
      wr(SLLC_OFS_ILAS_LINK_TEST, {dl[i], 4'h0});
      idle();
      repeat (12) @(posedge clk);
      n = 0;
      while (!mfb && n < 50) begin @(posedge clk); n++; end
      rel <= 1'b1; cnt = 0; n = 0;
      while (!ilas && n < 300) begin @(posedge clk); n++; if (mfb) cnt++; end
      check(9'(cnt), 9'(dl[i]) + 9'h1);
      n = 0;
      while (ilas && n < 100) begin @(posedge clk); n++; end
      repeat (2) @(posedge clk);
      rd(SLLC_OFS_LINK_STATUS, 8'h80);
      idle();
      for (int k = 0; k < 10; k++)
      begin
        h[k % 3] = 9'($urandom);
        user_char <= h[k % 3];
        @(posedge clk);
        if (k > 1) check(tx_char, h[(k - 1) % 3]);
      end
      rel <= 1'b0;
      user_char <= 9'h000;
      @(posedge clk);
    end
    $display("alignment delay done");
    // Test codes override the link with user data held still
    foreach (cd[i])
    begin
      wr(SLLC_OFS_ILAS_LINK_TEST, {5'h00, cd[i]});
      idle();
      repeat (4) @(posedge clk);
      mk = (cd[i] == 3'h1 || cd[i] == 3'h5); ch = 1'b0; v = tx_char.octet;
      for (int k = 0; k < 40; k++)
      begin
        @(posedge clk);
        if (cd[i] == 3'h1) check(tx_char, {1'b0, SLLC_D21_5});
        if (cd[i] == 3'h4 || cd[i] == 3'h6)
          mk |= (tx_char === {1'b1, (cd[i] == 3'h4) ? SLLC_K28_5 : SLLC_K28_3});
        else
          mk &= (tx_char.is_ctrl === 1'b0);
        ch |= (tx_char.octet !== v);
      end
      check({8'h00, mk}, 9'h001);
      if (cd[i] != 3'h1) check({8'h00, ch}, 9'h001);
    end
    wr(SLLC_OFS_ILAS_LINK_TEST, 8'h00);
    idle();
    $display("test codes done");
    // Phase offset shifts the next boundary after the sync pulse
    for (int i = 0; i < 2; i++)
    begin
      wr(SLLC_OFS_MF_PHASE, i ? 8'h03 : 8'h00);
      idle();
      repeat (10) @(posedge clk);
      sysref <= 1'b1;
      repeat (6) @(posedge clk);
      sysref <= 1'b0; n = 6;
      while (!mfb && n < 40) begin @(posedge clk); n++; end
      dd[i] = n;
    end
    check(9'(dd[0] - dd[1]), 9'h003);
    $display("phase offset done");
    wrap_up();
  end
endmodule

bind sllc_link_ctrl sllc_link_ctrl_checker chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sync_request_input(sync_request_input), .tx_char(tx_char), .mf_boundary(mf_boundary),
  .ilas_active(ilas_active));
`default_nettype wire
